//--- design/fcsr_defines.svh
`ifndef FCSR_DEFINES_SVH
`define FCSR_DEFINES_SVH
// register indices; byte address is four times the index
`define FCSR_IDX_STATUS 16'h303C
`define FCSR_IDX_OSC 16'h303E
`define FCSR_IDX_CTRL 16'h3040
`define FCSR_IDX_TRIM 16'h3041
`define FCSR_IDX_IST 16'h3042
`define FCSR_IDX_IMSK 16'h3043
`define FCSR_AW 18
`define FCSR_ADDR(i) ({(i), 2'b00})
// status fields
`define FCSR_ST_LOL 7
`define FCSR_ST_LOCK 6
`define FCSR_ST_REF 4
`define FCSR_ST_MODE 3:2
// oscillator control field
`define FCSR_OSC_EN 7
// control fields
`define FCSR_C_LOOP 0
`define FCSR_C_REF 1
`define FCSR_C_MODE 3:2
`define FCSR_C_DIV 6:4
`define FCSR_C_LOCK_LOST_IRQ_ENABLE 7
// event bits
`define FCSR_EV_ACQ 0
`define FCSR_EV_MODE 1
`define FCSR_EV_W 2
// reset values
`define FCSR_RST_CTRL 8'h03
`define FCSR_RST_TRIM 8'h80
`define FCSR_RST_OSC 1'h0
// bus answers
`define FCSR_RESP_OK 2'h0
`define FCSR_RESP_ERR 2'h2
// lock acquire time
`define FCSR_CLK_MHZ 200
`define FCSR_ACQ_NS 1000
`define FCSR_ACQ_CYC ((`FCSR_ACQ_NS * `FCSR_CLK_MHZ + 999) / 1000)
`define FCSR_CNT_W 12
`endif

//--- design/fcsr_pkg.sv
package fcsr_pkg;
  typedef enum logic [1:0] {
    LK_UNLOCKED,
    LK_ACQUIRE,
    LK_LOCKED
  } fcsr_lock_t;
  typedef enum logic [1:0] {
    MODE_LOOP,
    MODE_BYP_INT,
    MODE_BYP_EXT,
    MODE_RSVD
  } fcsr_mode_t;
endpackage

//--- design/fcsr_top.sv
// Summary of operation
// - The sticky lock-lost flag in status bit 7 sets only when detection is on and an acquired lock drifts out of tolerance.
// - The lock-lost flag clears on reset or when software writes one to it while it is set.
// - Writing zero to the lock-lost flag leaves it unchanged.
// - With the lock-lost flag set, an interrupt is requested only if its enable is set.
// - Status bit 6 shows the present lock state, one while locked.
// - Lock detection is off whenever the loop is disabled.
// - While locked, a change of reference select, divider, or trim in internal-reference modes clears lock until reacquired.
// - Stop entry clears lock, which stays cleared until lock is reacquired.
// - Status bit 4 shows the active reference, zero external and one internal.
// - The reference status follows a select write only after synchronisation, not in the write cycle.
// - Status bits 3-2 show the clock mode: loop, bypassed internal, bypassed external, 11 reserved.
// - The clock-mode status follows a select write only after synchronisation.
// - Reserved status bits, bit 5 among them, are read-only zero.
// - Oscillator control bit 7 enables the oscillator module when one and disables it when zero.
// - The lock-lost interrupt enable in control bit 7 requests on loss of lock when set, none when clear.
`timescale 1ns/1ps
`include "fcsr_defines.svh"
module fcsr_top (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // axi4-lite write
  input wire logic [`FCSR_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [`FCSR_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // loop and stop pins
  input wire logic LOOP_LOCKED,
  input wire logic STOP_ENTRY,
  // outputs to the clock unit
  output logic LOOP_EN,
  output logic REF_SEL,
  output logic [1:0] CLK_MODE,
  output logic [2:0] REF_DIV,
  output logic [7:0] TRIM,
  output logic OSC_EN,
  output logic IRQ
);
  // ---------------- pin synchronisers
  logic [1:0] pin_in;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] filt_r;
  logic [1:0] filt_nxt;
  assign pin_in = {STOP_ENTRY, LOOP_LOCKED};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_comb begin
        filt_nxt[gi] = filt_r[gi];
        if (s2_r[gi] == s3_r[gi]) begin
          filt_nxt[gi] = s3_r[gi];
        end
      end
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
        end else if (CE) begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          filt_r[gi] <= filt_nxt[gi];
        end
      end
    end
  endgenerate

  // ---------------- axi slave handshake
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic bvalid_r, bvalid_nxt, arrdy_r, arrdy_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [`FCSR_AW-1:0] awaddr_r, awaddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wlane_r, wlane_nxt;
  logic wr_go, rd_go;
  logic [7:0] rd_val;
  logic rd_hit, wr_hit;

  // ce low freezes a standing ready pulse too: keep ce high while bus is busy
  // one write and one read in flight; address and data taken in any order
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_go = S_AXI_ARVALID && arrdy_r;

  always_comb begin
    awrdy_nxt = 1'b0;
    wrdy_nxt = 1'b0;
    arrdy_nxt = 1'b0;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (S_AXI_AWVALID && awrdy_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = S_AXI_AWADDR;
    end else if (S_AXI_AWVALID && !aw_hold_r) begin
      awrdy_nxt = 1'b1;
    end
    if (S_AXI_WVALID && wrdy_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA[7:0];
      wlane_nxt = S_AXI_WSTRB[0];
    end else if (S_AXI_WVALID && !w_hold_r) begin
      wrdy_nxt = 1'b1;
    end
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `FCSR_RESP_OK : `FCSR_RESP_ERR;
    end else if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_val};
      rresp_nxt = rd_hit ? `FCSR_RESP_OK : `FCSR_RESP_ERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && !arrdy_r && !rvalid_r) begin
      arrdy_nxt = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      arrdy_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `FCSR_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r <= `FCSR_RESP_OK;
      rdata_r <= 32'h00000000;
    end else if (CE) begin
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
      arrdy_r <= arrdy_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------- register file
  logic [7:0] ctrl_r, ctrl_nxt, trim_r, trim_nxt;
  logic osc_r, osc_nxt, lol_r, lol_nxt, irq_r, irq_nxt;
  logic ref_p_r, ref_p_nxt, ref_st_r, ref_st_nxt;
  logic [1:0] mode_p_r, mode_p_nxt, mode_st_r, mode_st_nxt;
  logic [`FCSR_EV_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
  logic wr_st, wr_osc, wr_ctrl, wr_trim, wr_msk, rd_ist;
  logic lol_evt, acq_evt, disturb, int_mode;
  logic [7:0] ctrl_w;
  logic [`FCSR_AW-1:0] ra;
  fcsr_pkg::fcsr_lock_t lk_st_r, lk_st_nxt;

  assign ra = S_AXI_ARADDR;
  assign wr_st = wr_go && wlane_r &&
                 awaddr_r == `FCSR_ADDR(`FCSR_IDX_STATUS);
  assign wr_osc = wr_go && wlane_r &&
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_OSC);
  assign wr_ctrl = wr_go && wlane_r &&
                   awaddr_r == `FCSR_ADDR(`FCSR_IDX_CTRL);
  assign wr_trim = wr_go && wlane_r &&
                   awaddr_r == `FCSR_ADDR(`FCSR_IDX_TRIM);
  assign wr_msk = wr_go && wlane_r &&
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_IMSK);
  assign rd_ist = rd_go && ra == `FCSR_ADDR(`FCSR_IDX_IST);
  assign wr_hit = awaddr_r == `FCSR_ADDR(`FCSR_IDX_STATUS) ||
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_OSC) ||
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_CTRL) ||
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_TRIM) ||
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_IST) ||
                  awaddr_r == `FCSR_ADDR(`FCSR_IDX_IMSK);
  assign int_mode = ctrl_r[`FCSR_C_REF] &&
                    ctrl_r[`FCSR_C_MODE] != fcsr_pkg::MODE_BYP_EXT;

  // reserved mode code is refused, the old select stays
  always_comb begin
    ctrl_w = wdata_r;
    if (wdata_r[`FCSR_C_MODE] == fcsr_pkg::MODE_RSVD) begin
      ctrl_w[`FCSR_C_MODE] = ctrl_r[`FCSR_C_MODE];
    end
  end

  assign disturb = (wr_ctrl &&
      (ctrl_w[`FCSR_C_REF] != ctrl_r[`FCSR_C_REF] ||
       ctrl_w[`FCSR_C_DIV] != ctrl_r[`FCSR_C_DIV])) ||
      (wr_trim && int_mode && wdata_r != trim_r);

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (ra)
      `FCSR_ADDR(`FCSR_IDX_STATUS): begin
        rd_val[`FCSR_ST_LOL] = lol_r;
        rd_val[`FCSR_ST_LOCK] = lk_st_r == fcsr_pkg::LK_LOCKED;
        rd_val[`FCSR_ST_REF] = ref_st_r;
        rd_val[`FCSR_ST_MODE] = mode_st_r;
      end
      `FCSR_ADDR(`FCSR_IDX_OSC): rd_val[`FCSR_OSC_EN] = osc_r;
      `FCSR_ADDR(`FCSR_IDX_CTRL): rd_val = ctrl_r;
      `FCSR_ADDR(`FCSR_IDX_TRIM): rd_val = trim_r;
      `FCSR_ADDR(`FCSR_IDX_IST): rd_val[`FCSR_EV_W-1:0] = ist_r;
      `FCSR_ADDR(`FCSR_IDX_IMSK): rd_val[`FCSR_EV_W-1:0] = imsk_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    trim_nxt = trim_r;
    osc_nxt = osc_r;
    imsk_nxt = imsk_r;
    ist_nxt = ist_r;
    lol_nxt = lol_r;
    if (wr_ctrl) ctrl_nxt = ctrl_w;
    if (wr_trim) trim_nxt = wdata_r;
    if (wr_osc) osc_nxt = wdata_r[`FCSR_OSC_EN];
    if (wr_msk) imsk_nxt = wdata_r[`FCSR_EV_W-1:0];
    // a write of zero is ignored; a new loss in the same cycle wins
    if (wr_st && wdata_r[`FCSR_ST_LOL]) begin
      lol_nxt = 1'b0;
    end
    if (lol_evt) begin
      lol_nxt = 1'b1;
    end
    if (rd_ist) ist_nxt = '0;
    if (acq_evt) begin
      ist_nxt[`FCSR_EV_ACQ] = 1'b1;
    end
    if (mode_p_r != mode_st_r) begin
      ist_nxt[`FCSR_EV_MODE] = 1'b1;
    end
    // two stages stand for the crossing into the clock unit's domain
    ref_p_nxt = ctrl_r[`FCSR_C_REF];
    ref_st_nxt = ref_p_r;
    mode_p_nxt = ctrl_r[`FCSR_C_MODE];
    mode_st_nxt = mode_p_r;
    irq_nxt = (lol_nxt && ctrl_nxt[`FCSR_C_LOCK_LOST_IRQ_ENABLE]) ||
              |(ist_nxt & imsk_nxt);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl_r <= `FCSR_RST_CTRL;
      trim_r <= `FCSR_RST_TRIM;
      osc_r <= `FCSR_RST_OSC;
      imsk_r <= '0;
      ist_r <= '0;
      lol_r <= 1'b0;
      ref_p_r <= 1'(`FCSR_RST_CTRL >> `FCSR_C_REF);
      ref_st_r <= 1'(`FCSR_RST_CTRL >> `FCSR_C_REF);
      mode_p_r <= fcsr_pkg::MODE_LOOP;
      mode_st_r <= fcsr_pkg::MODE_LOOP;
      irq_r <= 1'b0;
    end else if (CE) begin
      ctrl_r <= ctrl_nxt;
      trim_r <= trim_nxt;
      osc_r <= osc_nxt;
      imsk_r <= imsk_nxt;
      ist_r <= ist_nxt;
      lol_r <= lol_nxt;
      ref_p_r <= ref_p_nxt;
      ref_st_r <= ref_st_nxt;
      mode_p_r <= mode_p_nxt;
      mode_st_r <= mode_st_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ---------------- lock tracking
  logic [`FCSR_CNT_W-1:0] cnt_r, cnt_nxt;
  logic stop_q_r, stop_q_nxt, stop_evt;

  assign stop_evt = filt_r[1] && !stop_q_r;

  // lock is trusted only after the loop reports it for the acquire time
  always_comb begin
    lk_st_nxt = lk_st_r;
    cnt_nxt = cnt_r;
    lol_evt = 1'b0;
    acq_evt = 1'b0;
    stop_q_nxt = filt_r[1];
    case (lk_st_r)
      fcsr_pkg::LK_UNLOCKED: begin
        cnt_nxt = '0;
        if (filt_r[0]) begin
          lk_st_nxt = fcsr_pkg::LK_ACQUIRE;
        end
      end
      fcsr_pkg::LK_ACQUIRE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (!filt_r[0]) begin
          lk_st_nxt = fcsr_pkg::LK_UNLOCKED;
        end else if (cnt_r == `FCSR_CNT_W'(`FCSR_ACQ_CYC - 1)) begin
          lk_st_nxt = fcsr_pkg::LK_LOCKED;
          acq_evt = 1'b1;
        end
      end
      fcsr_pkg::LK_LOCKED: begin
        if (!filt_r[0]) begin
          lk_st_nxt = fcsr_pkg::LK_UNLOCKED;
          lol_evt = 1'b1;
        end
      end
      default: begin
        lk_st_nxt = fcsr_pkg::LK_UNLOCKED;
      end
    endcase
    if ((disturb || stop_evt) && lk_st_r != fcsr_pkg::LK_UNLOCKED) begin
      lk_st_nxt = fcsr_pkg::LK_ACQUIRE;
      cnt_nxt = '0;
      acq_evt = 1'b0;
      lol_evt = 1'b0;
    end
    if (!ctrl_r[`FCSR_C_LOOP]) begin
      lk_st_nxt = fcsr_pkg::LK_UNLOCKED;
      cnt_nxt = '0;
      lol_evt = 1'b0;
      acq_evt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lk_st_r <= fcsr_pkg::LK_UNLOCKED;
      cnt_r <= '0;
      stop_q_r <= 1'b0;
    end else if (CE) begin
      lk_st_r <= lk_st_nxt;
      cnt_r <= cnt_nxt;
      stop_q_r <= stop_q_nxt;
    end
  end

  // ---------------- outputs
  assign S_AXI_AWREADY = awrdy_r;
  assign S_AXI_WREADY = wrdy_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arrdy_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RRESP = rresp_r;
  assign S_AXI_RDATA = rdata_r;
  assign LOOP_EN = ctrl_r[`FCSR_C_LOOP];
  assign REF_SEL = ctrl_r[`FCSR_C_REF];
  assign CLK_MODE = ctrl_r[`FCSR_C_MODE];
  assign REF_DIV = ctrl_r[`FCSR_C_DIV];
  assign TRIM = trim_r;
  assign OSC_EN = osc_r;
  assign IRQ = irq_r;
endmodule

//--- tb/fcsr_assertions.sv
`timescale 1ns/1ps
`include "fcsr_defines.svh"
module fcsr_assertions (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // register bus
  input wire logic [`FCSR_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // clock unit
  input wire logic LOOP_EN,
  input wire logic OSC_EN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // remembers whether the read now answering targets the status register
  logic st_rd_r;
  logic st_rd_nxt;
  always_comb begin
    st_rd_nxt = st_rd_r;
    if (S_AXI_ARREADY) begin
      st_rd_nxt = (S_AXI_ARADDR == `FCSR_ADDR(`FCSR_IDX_STATUS));
    end
    if (!RST_N) begin
      st_rd_nxt = 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    st_rd_r <= st_rd_nxt;
  end
  sequence s_st_ans;
    S_AXI_RVALID && st_rd_r;
  endsequence
  sequence s_off;
    !LOOP_EN [*4];
  endsequence
  sequence s_wtake;
    S_AXI_AWREADY && S_AXI_WREADY;
  endsequence
  property p_rsvd;
    s_st_ans |-> S_AXI_RDATA[5] == 1'b0 && S_AXI_RDATA[1:0] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved status bit reads one");
  property p_mode;
    s_st_ans |-> S_AXI_RDATA[3:2] != 2'b11;
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock mode status shows reserved code");
  property p_nolock;
    s_off ##0 s_st_ans |-> S_AXI_RDATA[6] == 1'b0;
  endproperty
  a_nolock: assert property (p_nolock)
    else $error("lock shown while loop disabled");
  property p_osc;
    $changed(OSC_EN) |-> $rose(S_AXI_BVALID);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator enable moved without a write");
  property p_bhold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rhold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read response dropped early");
  property p_wresp;
    s_wtake |-> ##2 S_AXI_BVALID;
  endproperty
  a_wresp: assert property (p_wresp)
    else $error("write response late");
  property p_rresp;
    S_AXI_ARREADY |=> S_AXI_RVALID ##0 S_AXI_RDATA[31:8] == 24'h000000;
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("read response late or wide");
endmodule

//--- tb/fcsr_tb_top.sv
`timescale 1ns/1ps
`include "fcsr_defines.svh"
module fll_clock_status_reporting_tb_top;
  localparam logic [17:0] A_ST = `FCSR_ADDR(`FCSR_IDX_STATUS);
  localparam logic [17:0] A_OSC = `FCSR_ADDR(`FCSR_IDX_OSC);
  localparam logic [17:0] A_CTL = `FCSR_ADDR(`FCSR_IDX_CTRL);
  localparam logic [17:0] A_TRM = `FCSR_ADDR(`FCSR_IDX_TRIM);
  localparam logic [17:0] A_IST = `FCSR_ADDR(`FCSR_IDX_IST);
  localparam logic [17:0] A_MSK = `FCSR_ADDR(`FCSR_IDX_IMSK);
  localparam logic [17:0] A_BAD = 18'h0C0F4;
  localparam logic [1:0] OK = `FCSR_RESP_OK;
  localparam logic [1:0] ER = `FCSR_RESP_ERR;
  // margin covers the pin filter on top of the acquire count
  localparam int LK = `FCSR_ACQ_CYC + 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic lkd = 1'b0, stp = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, loop_en, ref_sel;
  logic osc_en, irq;
  logic [1:0] bresp, rresp, clk_mode;
  logic [2:0] ref_div;
  logic [7:0] trim;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  fcsr_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(1'b1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LOOP_LOCKED(lkd),
    .STOP_ENTRY(stp), .LOOP_EN(loop_en), .REF_SEL(ref_sel),
    .CLK_MODE(clk_mode), .REF_DIV(ref_div), .TRIM(trim), .OSC_EN(osc_en),
    .IRQ(irq));
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 50) begin
      n_mismatch++;
      $display("[FAIL] t=%0t write wait %h limit %h", $time, i, 50);
      results();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 50) begin
      n_mismatch++;
      $display("[FAIL] t=%0t read wait %h limit %h", $time, i, 50);
      results();
    end
    chk({30'h0, rresp}, {30'h0, er});
    if (er == OK) chk(rdata, exp);
  endtask
  task automatic t_reset();
    rd(A_ST, 32'h10, OK);
    rd(A_OSC, 32'h00, OK);
    rd(A_BAD, 32'h00, ER);
    wr(A_BAD, 8'hFF, ER);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_osc();
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'h80 : 8'h00;
      wr(A_OSC, v, OK);
      chk({31'h0, osc_en}, {31'h0, v[7]});
      rd(A_OSC, {24'h0, v}, OK);
    end
  endtask
  task automatic t_mode();
    logic [1:0] m;
    for (int k = 0; k < 6; k++) begin
      m = 2'(k / 2);
      wr(A_CTL, {4'h0, m, 1'(k % 2), 1'b1}, OK);
      chk({29'h0, clk_mode, ref_sel}, {29'h0, m, 1'(k % 2)});
      rd(A_ST, {27'h0, 1'(k % 2), m, 2'b00}, OK);
    end
    // two mode changes above leave the mode event pending
    rd(A_IST, 32'h02, OK);
    wr(A_MSK, 8'h02, OK);
    wr(A_CTL, 8'h07, OK);
    cyc(4);
    chk({31'h0, irq}, 32'h1);
    rd(A_IST, 32'h02, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(A_MSK, 8'h00, OK);
    wr(A_CTL, 8'h83, OK);
    // reserved mode code is refused, the old select stays
    wr(A_CTL, 8'h8F, OK);
    rd(A_CTL, 32'h83, OK);
  endtask
  task automatic t_lock();
    lkd <= 1'b1;
    cyc(LK);
    rd(A_ST, 32'h50, OK);
    chk({31'h0, irq}, 32'h0);
    lkd <= 1'b0;
    cyc(10);
    rd(A_ST, 32'h90, OK);
    chk({31'h0, irq}, 32'h1);
    wr(A_ST, 8'h00, OK);
    rd(A_ST, 32'h90, OK);
    wr(A_CTL, 8'h03, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(A_CTL, 8'h83, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(A_ST, 8'h80, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd(A_ST, 32'h10, OK);
  endtask
  task automatic t_relock();
    lkd <= 1'b1;
    cyc(LK);
    wr(A_CTL, 8'h93, OK);
    chk({29'h0, ref_div}, 32'h1);
    rd(A_ST, 32'h10, OK);
    cyc(LK);
    wr(A_TRM, 8'h81, OK);
    chk({24'h0, trim}, 32'h81);
    rd(A_ST, 32'h10, OK);
    cyc(LK);
    rd(A_ST, 32'h50, OK);
    stp <= 1'b1;
    cyc(10);
    rd(A_ST, 32'h10, OK);
    stp <= 1'b0;
    cyc(LK);
    rd(A_ST, 32'h50, OK);
  endtask
  task automatic t_dis();
    wr(A_CTL, 8'h92, OK);
    chk({31'h0, loop_en}, 32'h0);
    cyc(4);
    rd(A_ST, 32'h10, OK);
    lkd <= 1'b0;
    cyc(10);
    rd(A_ST, 32'h10, OK);
    chk({31'h0, irq}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_osc();
    t_mode();
    t_lock();
    t_relock();
    t_dis();
    results();
  end
endmodule
bind fcsr_top fcsr_assertions i_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .LOOP_EN(LOOP_EN), .OSC_EN(OSC_EN));
